// >>> dmsc_defs.svh
// Register addresses, bit positions and reset values for converter mode/status control
`ifndef DMSC_DEFS_SVH
`define DMSC_DEFS_SVH
`define DMSC_MODE_ADDR 8'hD1
`define DMSC_STAT_ADDR 8'hD8
`define DMSC_MODE_RST 8'h00
`define DMSC_STAT_RST 8'h00
`define DMSC_B_RDY_P 7
`define DMSC_B_RDY_A 6
`define DMSC_B_CAL 5
`define DMSC_B_NOREF 4
`define DMSC_B_ERR_P 3
`define DMSC_B_ERR_A 2
`define DMSC_B_EN_P 5
`define DMSC_B_EN_A 4
`define DMSC_MD_HI 2
`endif

// >>> dmsc_pkg.sv
// Types shared by the converter mode/status control files
package dmsc_pkg;
	typedef enum logic [2:0] {
		MD_PDOWN  = 3'h0,
		MD_IDLE   = 3'h1,
		MD_SINGLE = 3'h2,
		MD_CONT   = 3'h3,
		MD_ZS_INT = 3'h4,
		MD_FS_INT = 3'h5,
		MD_ZS_SYS = 3'h6,
		MD_FS_SYS = 3'h7
	} dmsc_mode_t;
	typedef enum logic [1:0] {
		SEL_PINS  = 2'h0,
		SEL_SHORT = 2'h1,
		SEL_VREF  = 2'h2
	} dmsc_sel_t;
	typedef enum logic {
		CH_IDLE = 1'b0,
		CH_BUSY = 1'b1
	} dmsc_chan_st_t;
endpackage

// >>> dmsc_chan_if.sv
// Control and flag signals between mode logic and one converter channel
`timescale 1ns/1ps
`default_nettype none
interface dmsc_chan_if;
	logic mwr;
	logic start;
	logic arm;
	logic run;
	logic cal_mode;
	logic rdy_clr;
	logic cal_block;
	logic force_ones;
	logic ready;
	logic err;
	logic busy;
	logic cal_evt;
	modport ctl (
		output mwr, start, arm, run, cal_mode, rdy_clr, cal_block, force_ones,
		input  ready, err, busy, cal_evt
	);
	modport chan (
		input  mwr, start, arm, run, cal_mode, rdy_clr, cal_block, force_ones,
		output ready, err, busy, cal_evt
	);
endinterface
`default_nettype wire

// >>> dmsc_chan.sv
// One converter channel: ready/error flags, result register, write inhibit
`timescale 1ns/1ps
`default_nettype none
module dmsc_chan #(
	parameter int W = 24
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Control from mode logic
	dmsc_chan_if.chan         c,
	// Converter datapath
	input  wire logic         done_in,
	input  wire logic         clamp_in,
	input  wire logic         cal_fail_in,
	input  wire logic [W-1:0] result_in,
	output logic      [W-1:0] result_q,
	output logic              cal_we
);
	if (W < 8 || W > 32) begin : g_chk
		$error("dmsc_chan: W must be 8 to 32");
	end

	dmsc_pkg::dmsc_chan_st_t st_q;
	dmsc_pkg::dmsc_chan_st_t st_d;
	logic         rdy_q;
	logic         err_q;
	logic         accept;
	logic         cal_bad;
	logic         wr_data;
	logic         err_set;
	logic [W-1:0] res_d;

	// A completion lost to a fresh mode write is dropped; that write reset the converter
	assign accept  = done_in && c.run && !rdy_q && !c.mwr;
	assign cal_bad = cal_fail_in || c.cal_block;
	assign wr_data = accept && !c.cal_mode;
	assign cal_we  = accept && c.cal_mode && !cal_bad;
	assign res_d   = c.force_ones ? {W{1'b1}} : result_in;
	assign err_set = (wr_data && (clamp_in || c.force_ones)) || (accept && c.cal_mode && cal_bad);

	assign c.ready   = rdy_q;
	assign c.err     = err_q;
	assign c.busy    = (st_q == dmsc_pkg::CH_BUSY);
	assign c.cal_evt = accept && c.cal_mode;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			dmsc_pkg::CH_IDLE: begin
				st_d = c.arm ? dmsc_pkg::CH_BUSY : dmsc_pkg::CH_IDLE;
			end
			dmsc_pkg::CH_BUSY: begin
				if (c.mwr) begin
					st_d = c.arm ? dmsc_pkg::CH_BUSY : dmsc_pkg::CH_IDLE;
				end else if (accept) begin
					st_d = dmsc_pkg::CH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q     <= dmsc_pkg::CH_IDLE;
			rdy_q    <= 1'b0;
			err_q    <= 1'b0;
			result_q <= '0;
		end else begin
			st_q  <= st_d;
			// Set wins over any clear in the same cycle
			rdy_q <= accept || (rdy_q && !c.start && !c.rdy_clr);
			err_q <= err_set || (err_q && !c.start);
			if (wr_data) begin
				result_q <= res_d;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	res_hold_a: assert property (rdy_q |=> $stable(result_q))
		else $error("result changed while ready set");
	clamp_err_a: assert property (wr_data && clamp_in |=> err_q)
		else $error("clamped result did not raise error");
	cal_block_a: assert property (accept && c.cal_mode && cal_bad |-> !cal_we ##1 (rdy_q && err_q))
		else $error("failed calibration wrote coefficients or missed flags");
endmodule
`default_nettype wire

// >>> dmsc_top.sv
// Mode register, status register and sequencing for the two converters
`timescale 1ns/1ps
`default_nettype none
`include "dmsc_defs.svh"
module dmsc_top #(
	parameter int PW = 24,
	parameter int AW = 16
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Special function register bus
	input  wire logic [7:0]    sfr_addr,
	input  wire logic [7:0]    sfr_wdata,
	input  wire logic          sfr_wr,
	output logic      [7:0]    sfr_rdata,
	// Reference detector
	input  wire logic          ref_fault,
	// Primary converter datapath
	input  wire logic          p_done,
	input  wire logic          p_clamp,
	input  wire logic          p_cal_fail,
	input  wire logic [PW-1:0] p_result,
	input  wire logic          p_ref_ext,
	output logic      [PW-1:0] p_data,
	output logic               p_cal_we,
	output logic               p_conv_reset,
	output logic               p_power_down,
	output logic               p_mod_clk_en,
	output dmsc_pkg::dmsc_sel_t p_input_sel,
	// Auxiliary converter datapath
	input  wire logic          a_done,
	input  wire logic          a_clamp,
	input  wire logic          a_cal_fail,
	input  wire logic [AW-1:0] a_result,
	input  wire logic          a_ref_ext,
	input  wire logic          a_temp_sel,
	output logic      [AW-1:0] a_data,
	output logic               a_cal_we,
	output logic               a_conv_reset,
	output logic               a_power_down,
	output logic               a_mod_clk_en,
	output dmsc_pkg::dmsc_sel_t a_input_sel
);
	if (PW < AW) begin : g_chk
		$error("dmsc_top: primary width below auxiliary width");
	end

	// Mode and status state
	dmsc_pkg::dmsc_mode_t md_q;
	logic        en_p_q;
	logic        en_a_q;
	logic        cal_q;
	logic        noref_q;
	logic        seq_q;
	logic [7:0]  rdata_q;

	// Decoded bus access
	dmsc_pkg::dmsc_mode_t new_md;
	logic        mode_wr;
	logic        stat_wr;
	logic        start;
	logic        arm_p;
	logic        arm_a;
	logic        rdy_clr_p;
	logic        rdy_clr_a;
	logic        run_p;
	logic        run_a;
	logic        active_any;
	logic        done_all;
	logic        is_cal;
	logic        cal_set;
	logic [7:0]  stat_rd;
	logic [7:0]  mode_rd;
	logic [7:0]  rd_mux;
	dmsc_pkg::dmsc_sel_t sel_d;

	dmsc_chan_if pc ();
	dmsc_chan_if ac ();

	assign mode_wr = sfr_wr && (sfr_addr == `DMSC_MODE_ADDR);
	assign stat_wr = sfr_wr && (sfr_addr == `DMSC_STAT_ADDR);
	assign new_md  = dmsc_pkg::dmsc_mode_t'(sfr_wdata[`DMSC_MD_HI:0]);
	// Idle is not a start, so it leaves the flags for software to read
	assign start   = mode_wr && (new_md >= dmsc_pkg::MD_SINGLE);
	// Continuous mode never finishes, so it is not armed for the return to power-down
	assign arm_p   = start && sfr_wdata[`DMSC_B_EN_P] && (new_md != dmsc_pkg::MD_CONT);
	assign arm_a   = start && sfr_wdata[`DMSC_B_EN_A] && (new_md != dmsc_pkg::MD_CONT);
	// Writing a one to a ready bit is ignored; only zeros clear
	assign rdy_clr_p = stat_wr && !sfr_wdata[`DMSC_B_RDY_P];
	assign rdy_clr_a = stat_wr && !sfr_wdata[`DMSC_B_RDY_A];
	assign is_cal  = md_q[`DMSC_MD_HI];
	assign run_p   = en_p_q && (md_q >= dmsc_pkg::MD_SINGLE);
	assign run_a   = en_a_q && (md_q >= dmsc_pkg::MD_SINGLE);
	assign active_any = (en_p_q || en_a_q) && (md_q != dmsc_pkg::MD_PDOWN);
	assign done_all = seq_q && !pc.busy && !ac.busy && !mode_wr;
	assign cal_set = pc.cal_evt || ac.cal_evt;

	// Converter power and reset controls
	assign p_power_down = !en_p_q || (md_q == dmsc_pkg::MD_PDOWN);
	assign a_power_down = !en_a_q || (md_q == dmsc_pkg::MD_PDOWN);
	assign p_conv_reset = mode_wr || !run_p;
	assign a_conv_reset = mode_wr || !run_a;
	assign p_mod_clk_en = !p_power_down;
	assign a_mod_clk_en = !a_power_down;

	// System calibrations leave the pins selected; the user drives the levels
	assign sel_d = (md_q == dmsc_pkg::MD_ZS_INT) ? dmsc_pkg::SEL_SHORT :
		(md_q == dmsc_pkg::MD_FS_INT) ? dmsc_pkg::SEL_VREF : dmsc_pkg::SEL_PINS;
	assign p_input_sel = sel_d;
	assign a_input_sel = sel_d;

	// Channel controls
	assign pc.mwr        = mode_wr;
	assign pc.start      = start;
	assign pc.arm        = arm_p;
	assign pc.run        = run_p;
	assign pc.cal_mode   = is_cal;
	assign pc.rdy_clr    = rdy_clr_p;
	assign pc.cal_block  = 1'b0;
	assign pc.force_ones = noref_q && p_ref_ext;
	assign ac.mwr        = mode_wr;
	assign ac.start      = start;
	assign ac.arm        = arm_a;
	assign ac.run        = run_a;
	assign ac.cal_mode   = is_cal;
	assign ac.rdy_clr    = rdy_clr_a;
	assign ac.cal_block  = a_temp_sel;
	assign ac.force_ones = noref_q && a_ref_ext;

	// Read decode; reserved bits stay zero
	assign stat_rd = {pc.ready, ac.ready, cal_q, noref_q, pc.err, ac.err, 2'b00};
	assign mode_rd = {2'b00, en_p_q, en_a_q, 1'b0, md_q};
	assign rd_mux  = (sfr_addr == `DMSC_STAT_ADDR) ? stat_rd :
		(sfr_addr == `DMSC_MODE_ADDR) ? mode_rd : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			md_q   <= dmsc_pkg::dmsc_mode_t'(`DMSC_MODE_RST);
			en_p_q <= 1'b0;
			en_a_q <= 1'b0;
			seq_q  <= 1'b0;
		end else if (mode_wr) begin
			// Software write beats the hardware return to power-down
			md_q   <= new_md;
			en_p_q <= sfr_wdata[`DMSC_B_EN_P];
			en_a_q <= sfr_wdata[`DMSC_B_EN_A];
			seq_q  <= arm_p || arm_a;
		end else if (done_all) begin
			md_q  <= dmsc_pkg::MD_PDOWN;
			seq_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cal_q   <= 1'b0;
			noref_q <= 1'b0;
			rdata_q <= `DMSC_STAT_RST;
		end else begin
			cal_q   <= cal_set || (cal_q && !start);
			noref_q <= active_any && ref_fault;
			rdata_q <= rd_mux;
		end
	end

	assign sfr_rdata = rdata_q;

	dmsc_chan #(
		.W (PW)
	) u_prim (
		.clk         (clk),
		.rst         (rst),
		.c           (pc.chan),
		.done_in     (p_done),
		.clamp_in    (p_clamp),
		.cal_fail_in (p_cal_fail),
		.result_in   (p_result),
		.result_q    (p_data),
		.cal_we      (p_cal_we)
	);

	dmsc_chan #(
		.W (AW)
	) u_aux (
		.clk         (clk),
		.rst         (rst),
		.c           (ac.chan),
		.done_in     (a_done),
		.clamp_in    (a_clamp),
		.cal_fail_in (a_cal_fail),
		.result_in   (a_result),
		.result_q    (a_data),
		.cal_we      (a_cal_we)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_arm;
		mode_wr && (arm_p || arm_a);
	endsequence
	sequence s_settle;
		!pc.busy && !ac.busy && !mode_wr;
	endsequence
	sequence s_done_p;
		p_done && run_p && !pc.ready && !mode_wr;
	endsequence
	sequence s_done_a;
		a_done && run_a && !ac.ready && !mode_wr;
	endsequence

	mode_reset_a: assert property ($past(rst) |-> md_q == dmsc_pkg::MD_PDOWN && !en_p_q && !en_a_q)
		else $error("mode register not cleared by reset");
	prim_ready_a: assert property (p_done && run_p && !pc.ready && !mode_wr |=> pc.ready)
		else $error("primary ready not set on completion");
	aux_ready_a: assert property (a_done && run_a && !ac.ready && !mode_wr |=> ac.ready)
		else $error("auxiliary ready not set on completion");
	flag_clear_a: assert property (start && !p_done && !a_done |=> !pc.ready && !pc.err && !cal_q)
		else $error("flags not cleared by start");
	cal_keep_a: assert property (cal_q && !start |=> cal_q)
		else $error("calibration-done cleared without start");
	noref_gate_a: assert property (!active_any |=> !noref_q)
		else $error("missing reference flagged while inactive");
	noref_set_a: assert property (active_any && ref_fault |=> noref_q ##0 pc.force_ones == p_ref_ext)
		else $error("missing reference not tracked");
	pdown_en_a: assert property (!en_p_q |-> p_power_down && p_conv_reset && !p_mod_clk_en)
		else $error("disabled primary not powered down");
	idle_hold_a: assert property (md_q == dmsc_pkg::MD_IDLE && en_a_q |-> a_conv_reset && a_mod_clk_en)
		else $error("idle mode not holding reset with clocks");
	arm_busy_a: assert property (s_arm |=> seq_q && (pc.busy || ac.busy))
		else $error("armed converter not busy");
	auto_ret_a: assert property (seq_q ##0 s_settle |=> md_q == dmsc_pkg::MD_PDOWN)
		else $error("mode field not returned to power-down");
	mwr_reset_a: assert property (mode_wr |-> p_conv_reset && a_conv_reset)
		else $error("mode write did not reset converters");
	zs_short_a: assert property (md_q == dmsc_pkg::MD_ZS_INT |-> p_input_sel == dmsc_pkg::SEL_SHORT)
		else $error("zero-scale calibration input not shorted");
	rsvd_zero_a: assert property (sfr_addr == `DMSC_STAT_ADDR |=> sfr_rdata[1:0] == 2'b00)
		else $error("reserved status bits read nonzero");
	rsvd_mode_a: assert property (sfr_addr == `DMSC_MODE_ADDR |=>
		sfr_rdata[7:6] == 2'b00 && !sfr_rdata[3])
		else $error("reserved mode bits read nonzero");

	// Read data is registered, so it shows one cycle behind its address
	rd_mode_a: assert property (sfr_addr == `DMSC_MODE_ADDR |=>
		sfr_rdata == $past(mode_rd))
		else $error("mode register read wrong");
	rd_stat_a: assert property (sfr_addr == `DMSC_STAT_ADDR |=>
		sfr_rdata == $past(stat_rd))
		else $error("status register read wrong");
	unmapped_rd_a: assert property (sfr_addr != `DMSC_MODE_ADDR && sfr_addr != `DMSC_STAT_ADDR |=>
		sfr_rdata == 8'h00)
		else $error("unmapped address read nonzero");
	mode_load_a: assert property (mode_wr |=> mode_rd == ($past(sfr_wdata) & 8'h37))
		else $error("mode write not loaded");

	cal_set_p_a: assert property (s_done_p ##0 is_cal |=> cal_q)
		else $error("calibration-done not set by primary");
	cal_aux_set_a: assert property (s_done_a ##0 is_cal |=> cal_q)
		else $error("calibration-done not set by auxiliary");
	prim_rdy_clr_a: assert property (rdy_clr_p && !(p_done && run_p) |=> !pc.ready)
		else $error("primary ready not cleared by zero write");
	aux_rdy_clr_a: assert property (rdy_clr_a && !(a_done && run_a) |=> !ac.ready)
		else $error("auxiliary ready not cleared by zero write");
	aux_err_clr_a: assert property (start |=> !ac.err && !ac.ready)
		else $error("auxiliary flags not cleared by start");
	noref_clr_a: assert property (!ref_fault |=> !noref_q)
		else $error("missing reference kept with valid reference");

	aux_pdown_a: assert property (!en_a_q |-> a_power_down && a_conv_reset && !a_mod_clk_en)
		else $error("disabled auxiliary not powered down");
	fs_vref_a: assert property (md_q == dmsc_pkg::MD_FS_INT |->
		p_input_sel == dmsc_pkg::SEL_VREF && a_input_sel == dmsc_pkg::SEL_VREF)
		else $error("full-scale calibration input not on reference");
	sys_pins_a: assert property (md_q >= dmsc_pkg::MD_ZS_SYS |->
		p_input_sel == dmsc_pkg::SEL_PINS && a_input_sel == dmsc_pkg::SEL_PINS)
		else $error("system calibration input not on pins");
	cont_stay_a: assert property (md_q == dmsc_pkg::MD_CONT && !mode_wr |=>
		md_q == dmsc_pkg::MD_CONT)
		else $error("continuous mode left without a write");
	idle_keep_a: assert property (md_q == dmsc_pkg::MD_IDLE && !mode_wr |=>
		md_q == dmsc_pkg::MD_IDLE)
		else $error("idle mode left without a write");
endmodule
`default_nettype wire

// >>> dmsc_conv_model.sv
// Behavioural converter datapath that produces completion pulses
`timescale 1ns/1ps
`default_nettype none
module dmsc_conv_model #(
	parameter int W   = 24,
	parameter int LAT = 20
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Control from the block
	input  wire logic         conv_reset,
	input  wire logic         power_down,
	// Value to report
	input  wire logic [W-1:0] value,
	output logic              done,
	output logic      [W-1:0] result
);
	int cnt;
	// Counting restarts on every converter reset, as a real filter would
	always @(posedge clk) begin
		if (rst || conv_reset || power_down) begin
			cnt <= 0;
			done <= 1'b0;
		end else begin
			cnt <= (cnt == LAT - 1) ? 0 : cnt + 1;
			done <= (cnt == LAT - 1);
		end
	end
	// Result only valid beside done; inverted otherwise so a stale sample shows
	assign result = done ? value : ~value;
endmodule
`default_nettype wire

// >>> dmsc_top_tb.sv
// Self-checking bench for converter mode and status control
`timescale 1ns/1ps
`default_nettype none
module dmsc_top_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        sfr_wr = 1'b0;
	logic [7:0]  sfr_rdata;
	logic        ref_fault = 1'b0;
	logic        p_done, p_clamp = 1'b0, p_cal_fail = 1'b0, p_ref_ext = 1'b0;
	logic        a_done, a_clamp = 1'b0, a_cal_fail = 1'b0, a_ref_ext = 1'b0;
	logic        a_temp_sel = 1'b0;
	logic [23:0] p_result, p_data, p_val = 24'h00_0000, m_pd = 24'h00_0000;
	logic [15:0] a_result, a_data, a_val = 16'h0000, m_ad = 16'h0000;
	logic        p_cal_we, p_conv_reset, p_power_down, p_mod_clk_en;
	logic        a_cal_we, a_conv_reset, a_power_down, a_mod_clk_en;
	dmsc_pkg::dmsc_sel_t p_input_sel, a_input_sel;
	logic [7:0]  m_mode = 8'h00, m_stat = 8'h00;
	logic [1:0]  arm = 2'b00;
	logic        ret = 1'b0;
	int          n_mismatch = 0;
	int          comparisons = 0;

	always #5 clk = ~clk;

	dmsc_top u_dmsc_top (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
		.sfr_rdata, .ref_fault, .p_done, .p_clamp, .p_cal_fail, .p_result, .p_ref_ext,
		.p_data, .p_cal_we, .p_conv_reset, .p_power_down, .p_mod_clk_en, .p_input_sel,
		.a_done, .a_clamp, .a_cal_fail, .a_result, .a_ref_ext, .a_temp_sel, .a_data,
		.a_cal_we, .a_conv_reset, .a_power_down, .a_mod_clk_en, .a_input_sel);
	dmsc_conv_model #(.W(24), .LAT(20)) u_dmsc_conv_model (.clk, .rst,
		.conv_reset(p_conv_reset), .power_down(p_power_down), .value(p_val),
		.done(p_done), .result(p_result));
	dmsc_conv_model #(.W(16), .LAT(30)) u_dmsc_conv_model_a (.clk, .rst,
		.conv_reset(a_conv_reset), .power_down(a_power_down), .value(a_val),
		.done(a_done), .result(a_result));

	// Reference model of the two registers and result registers
	always @(posedge clk) begin : model
		logic [7:0] om;
		logic mw, nr, ap, aa;
		om = m_mode;
		mw = sfr_wr && sfr_addr == 8'hD1;
		nr = m_stat[4];
		ap = p_done && om[5] && om[2:0] >= 3'h2 && !m_stat[7] && !mw;
		aa = a_done && om[4] && om[2:0] >= 3'h2 && !m_stat[6] && !mw;
		if (rst) begin
			m_mode = 8'h00;
			m_stat = 8'h00;
			m_pd = 24'h00_0000;
			m_ad = 16'h0000;
			arm = 2'b00;
			ret = 1'b0;
		end else begin
			chk("p_cal_we", p_cal_we, ap && om[2] && !p_cal_fail);
			chk("a_cal_we", a_cal_we, aa && om[2] && !a_cal_fail && !a_temp_sel);
			m_stat[4] = (om[5] || om[4]) && om[2:0] != 3'h0 && ref_fault;
			if (ret && !mw)
				m_mode[2:0] = 3'h0;
			if (sfr_wr && sfr_addr == 8'hD8)
				m_stat[7:6] = m_stat[7:6] & sfr_wdata[7:6];
			if (mw) begin
				m_mode = sfr_wdata & 8'h37;
				arm = {sfr_wdata[4], sfr_wdata[5]};
				if (sfr_wdata[2:0] >= 3'h2)
					m_stat = m_stat & 8'h10;
			end
			if (ap) begin
				m_stat[7] = 1'b1;
				arm[0] = 1'b0;
				m_stat[3] |= p_clamp || (p_ref_ext && nr) || (om[2] && p_cal_fail);
				m_stat[5] |= om[2];
				if (!om[2])
					m_pd = (p_ref_ext && nr) ? 24'hFF_FFFF : p_val;
			end
			if (aa) begin
				m_stat[6] = 1'b1;
				arm[1] = 1'b0;
				m_stat[2] |= a_clamp || (a_ref_ext && nr) || (om[2] && (a_cal_fail || a_temp_sel));
				m_stat[5] |= om[2];
				if (!om[2])
					m_ad = (a_ref_ext && nr) ? 16'hFFFF : a_val;
			end
			ret = (ap || aa) && arm == 2'b00 && om[2:0] != 3'h3;
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		#1;
		if (a == 8'hD1)
			chk("conv_reset", {p_conv_reset, a_conv_reset}, 2'b11);
		@(posedge clk);
		sfr_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		@(posedge clk);
		#1;
		d = sfr_rdata;
	endtask

	task automatic regs();
		logic [7:0] d;
		repeat (3) @(posedge clk);
		rd(8'hD1, d);
		chk("mode", d, m_mode);
		rd(8'hD8, d);
		chk("status", d, m_stat);
		chk("p_data", p_data, m_pd);
		chk("a_data", a_data, m_ad);
	endtask

	// Waits for the ready bits in mask, bounded so a dead channel cannot hang
	task automatic poll(input logic [7:0] mask);
		logic [7:0] d;
		int i;
		d = 8'h00;
		for (i = 0; i < 200 && (d & mask) != mask; i++)
			rd(8'hD8, d);
		chk("ready wait", d & mask, mask);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin : watchdog
		#500_000;
		n_mismatch++;
		end_of_test();
	end

	initial begin : main
		logic [7:0] d;
		int r, m, en;
		void'($urandom(32'hf91d_dec2));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("reset outs", {p_power_down, p_conv_reset, p_mod_clk_en, p_input_sel}, 5'h18);
		wr(8'h55, 8'hFF);
		rd(8'h55, d);
		chk("unmapped", d, 8'h00);
		regs();
		for (r = 0; r < 2; r++) begin
			for (m = 2; m < 8; m++) begin
				en = $urandom_range(3, 1);
				@(posedge clk);
				p_val <= 24'($urandom);
				a_val <= 16'($urandom);
				p_clamp <= m < 4 && $urandom_range(1, 0);
				a_clamp <= m < 4 && $urandom_range(1, 0);
				ref_fault <= m < 4 && $urandom_range(1, 0);
				p_ref_ext <= $urandom_range(1, 0);
				a_ref_ext <= $urandom_range(1, 0);
				p_cal_fail <= m > 3 && $urandom_range(1, 0);
				a_cal_fail <= m > 3 && $urandom_range(1, 0);
				a_temp_sel <= m > 3 && $urandom_range(1, 0);
				// Bit 3 set on purpose: reserved, must read back as zero
				wr(8'hD1, {2'b11, en[1:0], 1'b1, m[2:0]});
				chk("power_down", {p_power_down, a_power_down}, {~en[1], ~en[0]});
				chk("input_sel", {p_input_sel, a_input_sel},
					m == 4 ? 4'h5 : m == 5 ? 4'hA : 4'h0);
				poll({en[1:0], 6'h00});
				regs();
				if (m == 3) begin
					@(posedge clk);
					p_val <= ~p_val;
					a_val <= ~a_val;
					repeat (40) @(posedge clk);
					regs();
					wr(8'hD8, 8'h3F);
					poll({en[1:0], 6'h00});
					regs();
				end
			end
		end
		@(posedge clk);
		ref_fault <= 1'b1;
		wr(8'hD1, 8'h31);
		chk("idle", {p_conv_reset, p_mod_clk_en, p_power_down, a_conv_reset, a_mod_clk_en,
			a_power_down}, 6'h36);
		regs();
		wr(8'hD1, 8'h30);
		regs();
		end_of_test();
	end
endmodule
`default_nettype wire
